// File: hw/reg_link_pkg.sv
// constants and types shared by the two-wire register access slave
package reg_link_pkg;

	// ------------------------------------------------------------------
	// slave addresses (write and read direction, low and high pair)
	// ------------------------------------------------------------------
	localparam logic [7:0] WR_ADDR_LO = 8'h88;
	localparam logic [7:0] WR_ADDR_HI = 8'h8c;
	localparam logic [7:0] RD_ADDR_LO = 8'h89;
	localparam logic [7:0] RD_ADDR_HI = 8'h8d;

	// ------------------------------------------------------------------
	// bit slots within one byte frame
	// ------------------------------------------------------------------
	localparam logic [3:0] BIT_FIRST = 4'h1; // count after the first sampled bit
	localparam logic [3:0] BIT_LAST  = 4'h7; // count while the eighth bit is sampled
	localparam logic [3:0] ACK_SLOT  = 4'h8; // count during the acknowledge pulse

	// ------------------------------------------------------------------
	// general control register and its bits
	// ------------------------------------------------------------------
	localparam logic [7:0] GENERAL_IDX     = 8'h03;
	localparam int         BTN_DISABLE_BIT = 3;
	localparam int         SOFT_CONFIG_BIT = 4;
	localparam logic [7:0] REG_RESET       = 8'h00;

	// ------------------------------------------------------------------
	// transaction phase, gray coded along idle-addr-index-data-done
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		PH_IDLE   = 3'h0,
		PH_ADDR   = 3'h1,
		PH_INDEX  = 3'h3,
		PH_DATA   = 3'h2,
		PH_DONE   = 3'h6,
		PH_IGNORE = 3'h7
	} phase_t;

endpackage

// File: hw/reg_link_slave.sv
// two-wire slave port giving a host write and read access to 8-bit registers
// ------------------------------------------------------------------
// ------------------------------------------------------------------
module reg_link_slave #(
	parameter int IDX_W = 8
) (
	// system clock and reset
	input  wire logic             clock,
	input  wire logic             reset_n,
	// two-wire link, clock driven by the host
	input  wire logic             scl,
	input  wire logic             sda_i,
	output logic                  sda_o_ff,
	output logic                  sda_oe_ff,
	// static strap
	input  wire logic             bus_address_select,
	// register writes seen by the core, system clock domain
	output logic                  reg_wr_pulse_ff,
	output logic [IDX_W-1:0]      reg_wr_index_ff,
	output logic [7:0]            reg_wr_data_ff,
	// control bits and link status
	output logic                  button_control_disable_ff,
	output logic                  software_config_enable_ff,
	output logic                  bus_busy_ff
);

	// ------------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------------
	logic                 link_rst_ff, start_tog_ff, stop_tog_ff, start_seen_ff, stop_seen_ff;
	logic [1:0]           asel_sync_ff;
	reg_link_pkg::phase_t phase_ff;
	logic [3:0]           cnt_ff;
	logic [7:0]           shreg_ff, data_ff;
	logic                 ack_ff, dir_rd_ff, wr_tog_ff;
	logic [IDX_W-1:0]     index_ff;
	logic [7:0]           mem [2**IDX_W];
	logic [2:0]           wr_sync_ff;
	logic [1:0]           sta_sync_ff, sto_sync_ff;
	logic                 sta_last_ff, sto_last_ff, new_start, new_stop;
	logic [7:0]           rx_byte, rd_byte, wr_addr, rd_addr;
	logic                 rd_bit, byte_end, wr_commit;

	// ------------------------------------------------------------------
	// reset for the link domain, applied asynchronously to its flops but not to the register array
	// ------------------------------------------------------------------
	always_ff @(posedge clock) begin
		link_rst_ff <= ~reset_n;
	end

	// data line edges while the clock is high mark bus conditions
	always_ff @(negedge sda_i or posedge link_rst_ff) begin
		if (link_rst_ff)
			start_tog_ff <= 1'b0;
		else if (scl)
			start_tog_ff <= ~start_tog_ff;
	end
	always_ff @(posedge sda_i or posedge link_rst_ff) begin
		if (link_rst_ff)
			stop_tog_ff <= 1'b0;
		else if (scl)
			stop_tog_ff <= ~stop_tog_ff;
	end

	// ------------------------------------------------------------------
	// link domain: receive on rising clock
	// ------------------------------------------------------------------
	assign new_start = start_tog_ff ^ start_seen_ff;
	assign new_stop  = stop_tog_ff ^ stop_seen_ff;
	assign rx_byte   = {shreg_ff[6:0], sda_i};
	assign byte_end  = !new_start && !new_stop && cnt_ff == reg_link_pkg::BIT_LAST;
	assign wr_addr   = asel_sync_ff[1] ? reg_link_pkg::WR_ADDR_HI : reg_link_pkg::WR_ADDR_LO;
	assign rd_addr   = asel_sync_ff[1] ? reg_link_pkg::RD_ADDR_HI : reg_link_pkg::RD_ADDR_LO;
	assign wr_commit = byte_end && phase_ff == reg_link_pkg::PH_DATA && !dir_rd_ff;
	assign rd_byte   = mem[index_ff];
	assign rd_bit    = rd_byte[3'h7 - cnt_ff[2:0]];

	// strap synchroniser
	always_ff @(posedge scl or posedge link_rst_ff) begin
		if (link_rst_ff)
			asel_sync_ff <= 2'h0;
		else
			asel_sync_ff <= {asel_sync_ff[0], bus_address_select};
	end

	// transaction sequencer
	always_ff @(posedge scl or posedge link_rst_ff) begin
		if (link_rst_ff) begin
			phase_ff      <= reg_link_pkg::PH_IDLE;
			cnt_ff        <= 4'h0;
			shreg_ff      <= 8'h00;
			ack_ff        <= 1'b0;
			dir_rd_ff     <= 1'b0;
			start_seen_ff <= 1'b0;
			stop_seen_ff  <= 1'b0;
		end else begin
			start_seen_ff <= start_tog_ff;
			stop_seen_ff  <= stop_tog_ff;
			if (new_start) begin
				phase_ff <= reg_link_pkg::PH_ADDR;
				cnt_ff   <= reg_link_pkg::BIT_FIRST;
				shreg_ff <= {7'h00, sda_i};
				ack_ff   <= 1'b0;
			end else if (new_stop) begin
				phase_ff <= reg_link_pkg::PH_IDLE;
				cnt_ff   <= 4'h0;
				ack_ff   <= 1'b0;
			end else begin
				unique case (phase_ff)
					reg_link_pkg::PH_ADDR, reg_link_pkg::PH_INDEX,
					reg_link_pkg::PH_DATA: begin
						if (cnt_ff == reg_link_pkg::ACK_SLOT) begin
							cnt_ff <= 4'h0;
							ack_ff <= 1'b0;
							if (phase_ff == reg_link_pkg::PH_ADDR)
								phase_ff <= reg_link_pkg::PH_INDEX;
							else if (phase_ff == reg_link_pkg::PH_INDEX)
								phase_ff <= reg_link_pkg::PH_DATA;
							else
								phase_ff <= reg_link_pkg::PH_DONE;
						end else begin
							shreg_ff <= rx_byte;
							cnt_ff   <= cnt_ff + 4'h1;
						end
						if (cnt_ff == reg_link_pkg::BIT_LAST) begin
							if (phase_ff == reg_link_pkg::PH_ADDR) begin
								ack_ff    <= rx_byte == wr_addr || rx_byte == rd_addr;
								dir_rd_ff <= rx_byte == rd_addr;
								if (rx_byte != wr_addr && rx_byte != rd_addr)
									phase_ff <= reg_link_pkg::PH_IGNORE;
							end else
								ack_ff <= !dir_rd_ff || phase_ff == reg_link_pkg::PH_INDEX;
						end
					end
					reg_link_pkg::PH_IDLE, reg_link_pkg::PH_DONE,
					reg_link_pkg::PH_IGNORE: begin
						cnt_ff <= 4'h0;
					end
					default: begin
						phase_ff <= reg_link_pkg::PH_IDLE;
					end
				endcase
			end
		end
	end

	// index capture and register store
	always_ff @(posedge scl or posedge link_rst_ff) begin
		if (link_rst_ff) begin
			index_ff  <= '0;
			data_ff   <= reg_link_pkg::REG_RESET;
			wr_tog_ff <= 1'b0;
		end else if (byte_end && phase_ff == reg_link_pkg::PH_INDEX) begin
			index_ff <= rx_byte[IDX_W-1:0];
		end else if (wr_commit) begin
			data_ff   <= rx_byte;
			wr_tog_ff <= ~wr_tog_ff;
		end
	end

	// register array, one byte per index
	always_ff @(posedge scl) begin
		if (wr_commit)
			mem[index_ff] <= rx_byte;
	end

	// ------------------------------------------------------------------
	// link domain: drive on falling clock, open drain, low only
	// ------------------------------------------------------------------
	always_ff @(negedge scl or posedge link_rst_ff) begin
		if (link_rst_ff)
			sda_oe_ff <= 1'b0;
		else if (new_start || phase_ff == reg_link_pkg::PH_IGNORE)
			sda_oe_ff <= 1'b0;
		else if (cnt_ff == reg_link_pkg::ACK_SLOT)
			sda_oe_ff <= ack_ff;
		else if (phase_ff == reg_link_pkg::PH_DATA && dir_rd_ff)
			sda_oe_ff <= ~rd_bit;
		else
			sda_oe_ff <= 1'b0;
	end

	// ------------------------------------------------------------------
	// system domain: write events, control bits, bus busy
	// ------------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			sda_o_ff    <= 1'b0;
			wr_sync_ff  <= 3'h0;
			sta_sync_ff <= 2'h0;
			sto_sync_ff <= 2'h0;
			sta_last_ff <= 1'b0;
			sto_last_ff <= 1'b0;
		end else begin
			sda_o_ff    <= 1'b0;
			wr_sync_ff  <= {wr_sync_ff[1:0], wr_tog_ff};
			sta_sync_ff <= {sta_sync_ff[0], start_tog_ff};
			sto_sync_ff <= {sto_sync_ff[0], stop_tog_ff};
			sta_last_ff <= sta_sync_ff[1];
			sto_last_ff <= sto_sync_ff[1];
		end
	end

	// write pulse with index and data, held steady by the link side
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			reg_wr_pulse_ff           <= 1'b0;
			reg_wr_index_ff           <= '0;
			reg_wr_data_ff            <= reg_link_pkg::REG_RESET;
			button_control_disable_ff <= 1'b0;
			software_config_enable_ff <= 1'b0;
		end else begin
			reg_wr_pulse_ff <= wr_sync_ff[2] ^ wr_sync_ff[1];
			if (wr_sync_ff[2] ^ wr_sync_ff[1]) begin
				reg_wr_index_ff <= index_ff;
				reg_wr_data_ff  <= data_ff;
				if (index_ff == reg_link_pkg::GENERAL_IDX[IDX_W-1:0]) begin
					button_control_disable_ff <= data_ff[reg_link_pkg::BTN_DISABLE_BIT];
					software_config_enable_ff <= data_ff[reg_link_pkg::SOFT_CONFIG_BIT];
				end
			end
		end
	end

	// busy from start until stop; a start in the same cycle wins
	always_ff @(posedge clock) begin
		if (!reset_n)
			bus_busy_ff <= 1'b0;
		else if (sta_sync_ff[1] ^ sta_last_ff)
			bus_busy_ff <= 1'b1;
		else if (sto_sync_ff[1] ^ sto_last_ff)
			bus_busy_ff <= 1'b0;
	end

	// ------------------------------------------------------------------
	// assertions and covers
	// ------------------------------------------------------------------
	a_start_restarts: assert property (@(posedge scl) disable iff (link_rst_ff)
		new_start |=> phase_ff == reg_link_pkg::PH_ADDR && cnt_ff == 4'h1)
		else $error("start did not restart the address phase");
	a_write_addr_ack: assert property (@(posedge scl) disable iff (link_rst_ff)
		byte_end && phase_ff == reg_link_pkg::PH_ADDR && rx_byte == wr_addr
		|=> ack_ff && !dir_rd_ff && sda_oe_ff)
		else $error("write address not acknowledged");
	a_read_addr_ack: assert property (@(posedge scl) disable iff (link_rst_ff)
		byte_end && phase_ff == reg_link_pkg::PH_ADDR && rx_byte == rd_addr
		|=> ack_ff && dir_rd_ff)
		else $error("read address not acknowledged");
	a_foreign_ignored: assert property (@(posedge scl) disable iff (link_rst_ff)
		byte_end && phase_ff == reg_link_pkg::PH_ADDR && rx_byte != wr_addr
		&& rx_byte != rd_addr |=> !ack_ff ##1 (!sda_oe_ff)[*3])
		else $error("foreign address drove the data line");
	a_ack_drives_low: assert property (@(posedge scl) disable iff (link_rst_ff)
		cnt_ff == reg_link_pkg::ACK_SLOT && ack_ff |-> sda_oe_ff)
		else $error("acknowledge pulse not driven low");
	a_nack_released: assert property (@(posedge scl) disable iff (link_rst_ff)
		phase_ff == reg_link_pkg::PH_DATA && dir_rd_ff && cnt_ff == reg_link_pkg::ACK_SLOT
		|-> !sda_oe_ff)
		else $error("data line pulled low in no-ack pulse");
	a_read_msb_first: assert property (@(posedge scl) disable iff (link_rst_ff)
		phase_ff == reg_link_pkg::PH_DATA && dir_rd_ff && cnt_ff < reg_link_pkg::ACK_SLOT
		&& !new_start |-> sda_oe_ff == ~rd_byte[3'h7 - cnt_ff[2:0]])
		else $error("read bit out of order");
	a_index_latched: assert property (@(posedge scl) disable iff (link_rst_ff)
		byte_end && phase_ff == reg_link_pkg::PH_INDEX
		|=> index_ff == $past(rx_byte[IDX_W-1:0]))
		else $error("register index not captured");
	a_write_stores: assert property (@(posedge scl) disable iff (link_rst_ff)
		wr_commit |=> mem[index_ff] == $past(rx_byte) && data_ff == $past(rx_byte))
		else $error("write data not stored");
	a_pulse_single: assert property (@(posedge clock) disable iff (!reset_n)
		reg_wr_pulse_ff |=> !reg_wr_pulse_ff)
		else $error("write pulse longer than one cycle");

	c_write_done: cover property (@(posedge scl) disable iff (link_rst_ff)
		wr_commit ##1 cnt_ff == reg_link_pkg::ACK_SLOT);
	c_read_done: cover property (@(posedge scl) disable iff (link_rst_ff)
		phase_ff == reg_link_pkg::PH_DATA && dir_rd_ff ##1 phase_ff == reg_link_pkg::PH_DONE);
	c_foreign: cover property (@(posedge scl) disable iff (link_rst_ff)
		phase_ff == reg_link_pkg::PH_IGNORE);
	c_general_write: cover property (@(posedge clock) disable iff (!reset_n)
		reg_wr_pulse_ff && reg_wr_index_ff == reg_link_pkg::GENERAL_IDX[IDX_W-1:0]);

endmodule

// File: testbench/reg_link_host.sv
// host master model that clocks frames on the two-wire link
module reg_link_host (
	// link pins, data is released high when not pulled
	output logic      scl,
	output logic      sda_drv,
	input  wire logic sda
);
	timeunit 1ns;
	timeprecision 10ps;

	// link clock stands high and data released outside frames
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end

	// data falls while clock high, then clock parks low
	task automatic frame_start();
		#62.5 sda_drv = 1'b0;
		#62.5 scl = 1'b0;
	endtask

	// data rises while clock high, link then idles high
	task automatic frame_stop();
		#31.25 sda_drv = 1'b0;
		#31.25 scl = 1'b1;
		#62.5 sda_drv = 1'b1;
	endtask

	// one 125 ns pulse: bit set while low, wire sampled mid-high
	task automatic pulse(input logic b, output logic s);
		#31.25 sda_drv = b;
		#31.25 scl = 1'b1;
		#31.25 s = sda;
		#31.25 scl = 1'b0;
	endtask

	// eight bits msb first, then the acknowledge pulse with data released
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
		for (int i = 7; i >= 0; i--) pulse(tx[i], rx[i]);
		pulse(1'b1, ack);
	endtask
endmodule

// File: testbench/reg_link_slave_tb_top.sv
// self-checking bench for the two-wire register access slave
module reg_link_slave_tb_top;
	timeunit 1ns;
	timeprecision 100ps;

	// ------------------------------------------------------------------
	// clock, reset, pins and counters
	// ------------------------------------------------------------------
	logic       clock              = 1'b0;
	logic       reset_n            = 1'b0;
	logic       bus_address_select = 1'b0;
	logic       scl;
	logic       sda_drv;
	logic       sda_o_ff;
	logic       sda_oe_ff;
	logic       reg_wr_pulse_ff;
	logic [7:0] reg_wr_index_ff;
	logic [7:0] reg_wr_data_ff;
	logic       btn_dis;
	logic       soft_cfg;
	logic       bus_busy_ff;
	logic [7:0] rd_data;
	int         miscompares = 0;
	int         compares    = 0;
	int         cycles      = 0;
	int         writes      = 0;
	// open-drain wire with pull-up
	wire        sda = sda_oe_ff ? (sda_o_ff & sda_drv) : sda_drv;

	always #20 clock = ~clock;

	// ------------------------------------------------------------------
	// design and host model
	// ------------------------------------------------------------------
	reg_link_slave u_reg_link_slave (
		.clock(clock), .reset_n(reset_n), .scl(scl), .sda_i(sda),
		.sda_o_ff(sda_o_ff), .sda_oe_ff(sda_oe_ff),
		.bus_address_select(bus_address_select),
		.reg_wr_pulse_ff(reg_wr_pulse_ff), .reg_wr_index_ff(reg_wr_index_ff),
		.reg_wr_data_ff(reg_wr_data_ff), .button_control_disable_ff(btn_dis),
		.software_config_enable_ff(soft_cfg), .bus_busy_ff(bus_busy_ff)
	);
	reg_link_host u_reg_link_host (.scl(scl), .sda_drv(sda_drv), .sda(sda));

	// counts write pulses and cuts a hang short
	always @(posedge clock) begin
		cycles++;
		if (reg_wr_pulse_ff === 1'b1)
			writes++;
		if (cycles == 5000) begin
			miscompares++;
			end_of_test();
		end
	end

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic end_of_test();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// one whole frame: address, index, data; acks packed as {addr, index, data}
	task automatic run(input logic [7:0] addr, idx, dat, input logic [2:0] exp_ack,
			input int exp_wr);
		int         w0;
		logic [7:0] junk;
		logic       a0;
		logic       a1;
		logic       a2;
		w0 = writes;
		u_reg_link_host.frame_start();
		u_reg_link_host.xfer(addr, junk, a0);
		check("busy", {7'h00, bus_busy_ff}, 8'h01);
		check("sda_o", {7'h00, sda_o_ff}, 8'h00);
		u_reg_link_host.xfer(idx, junk, a1);
		u_reg_link_host.xfer(dat, rd_data, a2);
		u_reg_link_host.frame_stop();
		repeat (10) @(posedge clock);
		check("busy", {7'h00, bus_busy_ff}, 8'h00);
		check("acks", {5'h00, a0, a1, a2}, {5'h00, exp_ack});
		check("writes", 8'(writes - w0), 8'(exp_wr));
	endtask

	// back-to-back writes at the low write address reach the core side
	task automatic sc_write_low();
		run(8'h88, 8'h0f, 8'hf0, 3'b000, 1);
		check("wr_index", reg_wr_index_ff, 8'h0f);
		check("wr_data", reg_wr_data_ff, 8'hf0);
		run(8'h88, 8'h10, 8'h3c, 3'b000, 1);
		check("wr_index", reg_wr_index_ff, 8'h10);
	endtask

	// single-phase reads pick the indexed byte; no-ack pulse left released
	task automatic sc_read_back();
		run(8'h89, 8'h0f, 8'hff, 3'b001, 0);
		check("rd_data", rd_data, 8'hf0);
		run(8'h89, 8'h10, 8'hff, 3'b001, 0);
		check("rd_data", rd_data, 8'h3c);
	endtask

	// unselected pair and foreign addresses: no ack, no write, link recovers
	task automatic sc_foreign();
		logic [7:0] addrs [3] = '{8'h8c, 8'h8d, 8'h5a};
		foreach (addrs[i]) run(addrs[i], 8'h0f, 8'h00, 3'b111, 0);
		run(8'h89, 8'h0f, 8'hff, 3'b001, 0);
		check("rd_data", rd_data, 8'hf0);
	endtask

	// general control bits follow index 03h only
	task automatic sc_control();
		run(8'h88, 8'h03, 8'h18, 3'b000, 1);
		check("ctrl", {6'h00, btn_dis, soft_cfg}, 8'h03);
		run(8'h88, 8'h03, 8'h08, 3'b000, 1);
		check("ctrl", {6'h00, btn_dis, soft_cfg}, 8'h02);
		run(8'h88, 8'h04, 8'h18, 3'b000, 1);
		check("ctrl", {6'h00, btn_dis, soft_cfg}, 8'h02);
	endtask

	// strap high moves the device to the upper address pair
	task automatic sc_high_pair();
		@(posedge clock);
		bus_address_select <= 1'b1;
		run(8'h88, 8'h20, 8'h00, 3'b111, 0);
		run(8'h8c, 8'h20, 8'h5a, 3'b000, 1);
		run(8'h8d, 8'h20, 8'hff, 3'b001, 0);
		check("rd_data", rd_data, 8'h5a);
	endtask

	// reset for 8 cycles, then the scenarios in turn
	initial begin
		repeat (8) @(posedge clock);
		reset_n <= 1'b1;
		repeat (4) @(posedge clock);
		sc_write_low();
		sc_read_back();
		sc_foreign();
		sc_control();
		sc_high_pair();
		end_of_test();
	end
endmodule
